// ### hw/misc_ctrl_params.svh
/*
 constants for the socket miscellaneous control register.
 assumes inclusion by its bare name, from the design file and the bench.
*/
`ifndef MISC_CTRL_PARAMS_SVH
`define MISC_CTRL_PARAMS_SVH
`define MISC1_IO_INDEX 8'h16
`define MISC1_MEM_OFFSET 12'h816
`define MISC1_RESET 8'h00
`define MISC1_MM_BIT 0
`define MISC1_VSEL_BIT 1
`define MISC1_PMGT_BIT 2
`define MISC1_PSYS_BIT 3
`define MISC1_SPK_BIT 4
`define PWR_CTRL_VCC_BIT 4
`define PULSE_HIGH_CYC 4'h2
`define PULSE_LOW_CYC 4'h2
`endif

// ### hw/misc_ctrl_pkg.sv
/*
 types and logic of the per-socket miscellaneous control register:
 register decode, address float, card supply choice, interrupt pulsing
 and speaker mixing.
 assumes the params header sits beside it, one clock for the register
 side, and card speaker pins that arrive from outside that clock.
*/
// Summary of operation
// - bit 0 set floats socket address lines 25 to 4.
// - bit 0 acts only while the multimedia arm bit is one.
// - bit 1 zero picks 5 V, one picks 3 V at card power-up.
// - bit 1 combines with power control bit 4 to select card supply.
// - bit 1 survives a segment reset while power event enable is true.
// - bit 2 picks level or shareable pulse train for management interrupt.
// - bits 3 and 2 act only in external hardware interrupt signalling mode.
// - register answers at I/O index 16h and memory offset 816h.
// - bit 3 picks level or pulse train for system status interrupts.
// - bit 4 drives speaker output with XNOR of enabled sockets, else floats.
`timescale 1ns/100ps
`include "misc_ctrl_params.svh"
package misc_ctrl_pkg;
   typedef struct packed {
      logic compat;
      logic [1:0] scratch;
      logic spk_en;
      logic pulse_sys;
      logic pulse_mgt;
      logic vsel_3v;
      logic mm_en;
   } misc1_type;
   typedef struct packed {
      logic io_wr;
      logic mem_wr;
      logic [11:0] addr;
      logic [7:0] wdata;
   } reg_req_type;
   typedef enum logic [1:0] {
      P_IDLE = 2'b00,
      P_HIGH = 2'b01,
      P_LOW = 2'b10
   } pulse_state_type;
endpackage

module socket_misc_control_one
   import misc_ctrl_pkg::*;
#(
   parameter int N_SOCK = 2
) (
   // clock and reset
   input logic i_clk,
   input logic i_srst,
   // register access from the host bridge
   input reg_req_type i_req,
   input logic i_rd_io,
   input logic i_rd_mem,
   output logic [7:0] o_rdata,
   output logic o_rdata_valid,
   // companion bits from neighbouring registers and mode logic
   input logic i_mm_arm,
   input logic i_vcc_on,
   input logic i_pme_en,
   input logic i_seg_rst,
   input logic i_ext_hw_mode,
   // interrupt requests from the card status logic
   input logic i_mgt_req,
   input logic i_sys_req,
   // card speaker pins and per-socket speaker enables
   input logic [N_SOCK-1:0] i_card_spkr_n,
   input logic [N_SOCK-1:0] i_sock_spk_en,
   // socket side controls
   output logic o_addr_oe_n,
   output logic o_vcc_3v_en,
   output logic o_vcc_5v_en,
   // system side pins, bit 0 management, bit 1 card status
   output logic [1:0] o_system_interrupt_pins,
   output logic o_audio_output_pin,
   output logic o_audio_output_oe_n,
   // register contents for neighbouring logic
   output misc1_type o_ctrl
);

   // register state
   misc1_type ctrl_r;
   misc1_type ctrl_nxt;
   logic wr_hit;
   logic rd_hit;

   // speaker pin synchroniser
   logic [N_SOCK-1:0] spk_sync1_r;
   logic [N_SOCK-1:0] spk_sync1_nxt;
   logic [N_SOCK-1:0] spk_sync2_r;
   logic [N_SOCK-1:0] spk_sync2_nxt;

   // interrupt pulse sequencers
   pulse_state_type mgt_st_r;
   pulse_state_type mgt_st_nxt;
   logic [3:0] mgt_cnt_r;
   logic [3:0] mgt_cnt_nxt;
   pulse_state_type sys_st_r;
   pulse_state_type sys_st_nxt;
   logic [3:0] sys_cnt_r;
   logic [3:0] sys_cnt_nxt;
   logic [5:0] mgt_step;
   logic [5:0] sys_step;
   logic mgt_pulse;
   logic sys_pulse;

   // registered outputs
   logic addr_oe_n_r;
   logic addr_oe_n_nxt;
   logic vcc3_r;
   logic vcc3_nxt;
   logic vcc5_r;
   logic vcc5_nxt;
   logic [1:0] irq_r;
   logic [1:0] irq_nxt;
   logic aud_r;
   logic aud_nxt;
   logic aud_oe_n_r;
   logic aud_oe_n_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic rd_valid_r;
   logic rd_valid_nxt;

   // i/o cycles carry only the low index byte
   function automatic logic io_hit(input logic [11:0] a);
      io_hit = (a[7:0] == `MISC1_IO_INDEX);
   endfunction

   // memory cycles must match the full offset
   function automatic logic mem_hit(input logic [11:0] a);
      mem_hit = (a == `MISC1_MEM_OFFSET);
   endfunction

   // one step of a pulse train: high, then low gap, repeat while asked
   function automatic logic [5:0] pulse_next(
      input pulse_state_type st,
      input logic [3:0] cnt,
      input logic req
   );
      pulse_state_type st_n;
      logic [3:0] cnt_n;
      st_n = st;
      cnt_n = cnt;
      case (st)
         P_IDLE: begin
            if (req) begin
               st_n = P_HIGH;
               cnt_n = `PULSE_HIGH_CYC - 4'h1;
            end
         end
         P_HIGH: begin
            if (cnt != 4'h0) begin
               cnt_n = cnt - 4'h1;
            end else begin
               st_n = P_LOW;
               cnt_n = `PULSE_LOW_CYC - 4'h1;
            end
         end
         P_LOW: begin
            if (cnt != 4'h0) begin
               cnt_n = cnt - 4'h1;
            end else if (req) begin
               st_n = P_HIGH;
               cnt_n = `PULSE_HIGH_CYC - 4'h1;
            end else begin
               st_n = P_IDLE;
               cnt_n = 4'h0;
            end
         end
         default: begin
            st_n = P_IDLE;
            cnt_n = 4'h0;
         end
      endcase
      return {st_n, cnt_n};
   endfunction

   // address decode for both access paths
   assign wr_hit = (i_req.io_wr && io_hit(i_req.addr)) ||
                   (i_req.mem_wr && mem_hit(i_req.addr));
   assign rd_hit = (i_rd_io && io_hit(i_req.addr)) ||
                   (i_rd_mem && mem_hit(i_req.addr));

   // register next value; segment reset wins over a write in its cycle
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (i_srst) begin
         ctrl_nxt = misc1_type'(`MISC1_RESET);
      end else if (i_seg_rst) begin
         ctrl_nxt = misc1_type'(`MISC1_RESET);
         if (i_pme_en) begin
            ctrl_nxt.vsel_3v = ctrl_r.vsel_3v;
         end
      end else if (wr_hit) begin
         ctrl_nxt = misc1_type'(i_req.wdata);
      end
   end

   always_ff @(posedge i_clk) begin
      ctrl_r <= ctrl_nxt;
   end

   // speaker pins idle high, so reset to high avoids a false toggle
   always_comb begin
      spk_sync1_nxt = i_card_spkr_n;
      spk_sync2_nxt = spk_sync1_r;
      if (i_srst) begin
         spk_sync1_nxt = {N_SOCK{1'b1}};
         spk_sync2_nxt = {N_SOCK{1'b1}};
      end
   end

   always_ff @(posedge i_clk) begin
      spk_sync1_r <= spk_sync1_nxt;
      spk_sync2_r <= spk_sync2_nxt;
   end

   // pulse sequencers run always; the output mux picks level or pulse
   always_comb begin
      mgt_step = pulse_next(mgt_st_r, mgt_cnt_r, i_mgt_req);
      sys_step = pulse_next(sys_st_r, sys_cnt_r, i_sys_req);
      mgt_st_nxt = pulse_state_type'(mgt_step[5:4]);
      mgt_cnt_nxt = mgt_step[3:0];
      sys_st_nxt = pulse_state_type'(sys_step[5:4]);
      sys_cnt_nxt = sys_step[3:0];
      if (i_srst) begin
         mgt_st_nxt = P_IDLE;
         mgt_cnt_nxt = 4'h0;
         sys_st_nxt = P_IDLE;
         sys_cnt_nxt = 4'h0;
      end
   end

   always_ff @(posedge i_clk) begin
      mgt_st_r <= mgt_st_nxt;
      mgt_cnt_r <= mgt_cnt_nxt;
      sys_st_r <= sys_st_nxt;
      sys_cnt_r <= sys_cnt_nxt;
   end

   // pulse bits are ignored outside external hardware signalling
   assign mgt_pulse = i_ext_hw_mode & ctrl_r.pulse_mgt;
   assign sys_pulse = i_ext_hw_mode & ctrl_r.pulse_sys;

   // output next values; outputs lag the register by one cycle
   always_comb begin
      addr_oe_n_nxt = ctrl_r.mm_en & i_mm_arm;
      vcc3_nxt = i_vcc_on & ctrl_r.vsel_3v;
      vcc5_nxt = i_vcc_on & ~ctrl_r.vsel_3v;
      irq_nxt[0] = mgt_pulse ? (mgt_st_nxt == P_HIGH) : i_mgt_req;
      irq_nxt[1] = sys_pulse ? (sys_st_nxt == P_HIGH) : i_sys_req;
      // a disabled socket counts as high, so one socket passes through
      aud_nxt = ~^(spk_sync2_r | ~i_sock_spk_en);
      aud_oe_n_nxt = ~ctrl_r.spk_en;
      rdata_nxt = rd_hit ? ctrl_r : rdata_r;
      rd_valid_nxt = rd_hit;
      if (i_srst) begin
         addr_oe_n_nxt = 1'b0;
         vcc3_nxt = 1'b0;
         vcc5_nxt = 1'b0;
         irq_nxt = 2'b00;
         aud_nxt = 1'b1;
         aud_oe_n_nxt = 1'b1;
         rdata_nxt = 8'h00;
         rd_valid_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      addr_oe_n_r <= addr_oe_n_nxt;
      vcc3_r <= vcc3_nxt;
      vcc5_r <= vcc5_nxt;
      irq_r <= irq_nxt;
      aud_r <= aud_nxt;
      aud_oe_n_r <= aud_oe_n_nxt;
      rdata_r <= rdata_nxt;
      rd_valid_r <= rd_valid_nxt;
   end

   // pins and read port
   assign o_addr_oe_n = addr_oe_n_r;
   assign o_vcc_3v_en = vcc3_r;
   assign o_vcc_5v_en = vcc5_r;
   assign o_system_interrupt_pins = irq_r;
   assign o_audio_output_pin = aud_r;
   assign o_audio_output_oe_n = aud_oe_n_r;
   assign o_rdata = rdata_r;
   assign o_rdata_valid = rd_valid_r;
   assign o_ctrl = ctrl_r;

   // checks on what this block drives
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);

   addr_float_a: assert property (ctrl_r.mm_en && i_mm_arm |=> o_addr_oe_n)
      else $error("address lines not floated");
   arm_gate_a: assert property (!i_mm_arm |=> !o_addr_oe_n)
      else $error("address float without arm");
   vsel_3v_a: assert property (i_vcc_on && ctrl_r.vsel_3v
      |=> o_vcc_3v_en && !o_vcc_5v_en)
      else $error("3 V supply not chosen");
   vsel_5v_a: assert property (i_vcc_on && !ctrl_r.vsel_3v
      |=> o_vcc_5v_en && !o_vcc_3v_en)
      else $error("5 V supply not chosen");
   vsel_keep_a: assert property (i_seg_rst && i_pme_en
      |=> ctrl_r.vsel_3v == $past(ctrl_r.vsel_3v))
      else $error("voltage select lost");
   mgt_level_a: assert property (!ctrl_r.pulse_mgt
      |=> o_system_interrupt_pins[0] == $past(i_mgt_req))
      else $error("management line not level");
   pulse_high_a: assert property ($rose(o_system_interrupt_pins[0]) &&
      mgt_pulse && $past(mgt_pulse) |=> o_system_interrupt_pins[0])
      else $error("management pulse too short");
   mode_ignore_a: assert property (!i_ext_hw_mode
      |=> o_system_interrupt_pins[1] == $past(i_sys_req))
      else $error("pulse bit used outside mode");
   sys_level_a: assert property (!ctrl_r.pulse_sys
      |=> o_system_interrupt_pins[1] == $past(i_sys_req))
      else $error("status line not level");
   spk_float_a: assert property (!ctrl_r.spk_en |=> o_audio_output_oe_n)
      else $error("speaker driven while off");

   // main scenarios
   mgt_pulse_c: cover property (mgt_pulse && mgt_st_r == P_LOW);
   seg_keep_c: cover property (i_seg_rst && i_pme_en && ctrl_r.vsel_3v);
   spk_drive_c: cover property (!o_audio_output_oe_n);
   addr_float_c: cover property (o_addr_oe_n);

endmodule

// ### verification/tb_socket_misc_control_one.sv
/*
 bench for the socket miscellaneous control register, with a card
 socket model that drives the speaker pins.
 assumes the hw folder on the include path and the package compiled first.
*/
`timescale 1ns/100ps
`include "misc_ctrl_params.svh"

// card sockets: an empty socket leaves its speaker pin on the pull-up
module socket_model (
   input logic i_clk,
   input logic [1:0] i_present,
   input logic [1:0] i_card_spkr_n,
   output logic [1:0] o_spkr_n
);
   always @(negedge i_clk) begin
      o_spkr_n <= i_card_spkr_n | ~i_present;
   end
endmodule

module tb_socket_misc_control_one;
   import misc_ctrl_pkg::*;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   reg_req_type req = '0;
   logic rd_io = 1'b0;
   logic rd_mem = 1'b0;
   logic mm_arm = 1'b0;
   logic vcc_on = 1'b0;
   logic pme_en = 1'b0;
   logic seg_rst = 1'b0;
   logic ext_mode = 1'b0;
   logic mgt_req = 1'b0;
   logic sys_req = 1'b0;
   logic [1:0] present = 2'b00;
   logic [1:0] card_spkr = 2'b11;
   logic [1:0] sock_en = 2'b00;
   logic [1:0] spkr_pins;
   logic [7:0] rdata;
   logic rdata_valid;
   logic addr_oe_n;
   logic vcc3;
   logic vcc5;
   logic [1:0] irq_pins;
   logic aud;
   logic aud_oe_n;
   misc1_type ctrl;
   int bad_count = 0;
   int checked = 0;
   int seed = 32'hf7ba;
   logic [7:0] exp_q[$];
   logic [7:0] shadow;
   logic [4:0] pat;
   logic exp_b;

   // free-running clock, never stopped while pulses run
   always #5 i_clk = ~i_clk;

   socket_model sock_u (
      .i_clk(i_clk),
      .i_present(present),
      .i_card_spkr_n(card_spkr),
      .o_spkr_n(spkr_pins)
   );

   socket_misc_control_one dut_u (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_req(req),
      .i_rd_io(rd_io),
      .i_rd_mem(rd_mem),
      .o_rdata(rdata),
      .o_rdata_valid(rdata_valid),
      .i_mm_arm(mm_arm),
      .i_vcc_on(vcc_on),
      .i_pme_en(pme_en),
      .i_seg_rst(seg_rst),
      .i_ext_hw_mode(ext_mode),
      .i_mgt_req(mgt_req),
      .i_sys_req(sys_req),
      .i_card_spkr_n(spkr_pins),
      .i_sock_spk_en(sock_en),
      .o_addr_oe_n(addr_oe_n),
      .o_vcc_3v_en(vcc3),
      .o_vcc_5v_en(vcc5),
      .o_system_interrupt_pins(irq_pins),
      .o_audio_output_pin(aud),
      .o_audio_output_oe_n(aud_oe_n),
      .o_ctrl(ctrl)
   );

   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s exp %h seen %h", name, exp, seen);
      end
   endtask

   task test_done;
      if (exp_q.size() != 0) bad_count++;
      if (bad_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // one write, strobe held across one rising edge
   task automatic reg_write(input logic [11:0] a, input logic [7:0] d,
                            input logic use_mem);
      @(negedge i_clk);
      req.addr = a;
      req.wdata = d;
      req.io_wr = ~use_mem;
      req.mem_wr = use_mem;
      @(negedge i_clk);
      req.io_wr = 1'b0;
      req.mem_wr = 1'b0;
   endtask

   // one read; the expected byte is noted before the strobe rises
   task automatic reg_read(input logic [11:0] a, input logic use_mem,
                           input logic [7:0] exp);
      exp_q.push_back(exp);
      @(negedge i_clk);
      req.addr = a;
      rd_io = ~use_mem;
      rd_mem = use_mem;
      @(negedge i_clk);
      rd_io = 1'b0;
      rd_mem = 1'b0;
   endtask

   task automatic seg_pulse;
      @(negedge i_clk);
      seg_rst = 1'b1;
      @(negedge i_clk);
      seg_rst = 1'b0;
   endtask

   task automatic settle;
      repeat (2) @(negedge i_clk);
   endtask

   // read results are compared against the oldest note
   always @(negedge i_clk) begin
      if (rdata_valid) begin
         if (exp_q.size() == 0) begin
            bad_count++;
         end else begin
            check("rdata", rdata, exp_q.pop_front());
         end
      end
   end

   initial begin
      repeat (10) @(negedge i_clk);
      i_srst = 1'b0;
      reg_read(12'h016, 1'b0, 8'h00);
      for (int k = 0; k < 16; k++) begin
         shadow = 8'($random(seed));
         reg_write(k[0] ? 12'h816 : 12'h016, shadow, k[0]);
         reg_read(k[1] ? 12'h816 : 12'h016, k[1], shadow);
         check("ctrl", ctrl, shadow);
      end
      // neighbouring and mismatched addresses leave the register alone
      reg_write(12'h817, ~shadow, 1'b1);
      reg_write(12'h017, ~shadow, 1'b0);
      reg_write(12'h016, ~shadow, 1'b1);
      reg_read(12'h816, 1'b1, shadow);
      // address float needs both bits
      reg_write(12'h016, 8'h01, 1'b0);
      settle;
      check("addr_oe_n", {7'h00, addr_oe_n}, 8'h00);
      mm_arm = 1'b1;
      settle;
      check("addr_oe_n", {7'h00, addr_oe_n}, 8'h01);
      reg_write(12'h016, 8'h00, 1'b0);
      settle;
      check("addr_oe_n", {7'h00, addr_oe_n}, 8'h00);
      // supply choice
      vcc_on = 1'b1;
      settle;
      check("vcc_5v", {7'h00, vcc5}, 8'h01);
      check("vcc_3v", {7'h00, vcc3}, 8'h00);
      reg_write(12'h816, 8'h02, 1'b1);
      settle;
      check("vcc_3v", {7'h00, vcc3}, 8'h01);
      check("vcc_5v", {7'h00, vcc5}, 8'h00);
      vcc_on = 1'b0;
      settle;
      check("vcc_3v", {7'h00, vcc3}, 8'h00);
      // segment reset keeps only the voltage bit, and only when enabled
      pme_en = 1'b1;
      reg_write(12'h016, 8'hff, 1'b0);
      seg_pulse;
      reg_read(12'h816, 1'b1, 8'h02);
      pme_en = 1'b0;
      reg_write(12'h016, 8'hff, 1'b0);
      seg_pulse;
      reg_read(12'h016, 1'b0, 8'h00);
      // outside external mode the pulse bits change nothing
      reg_write(12'h016, 8'h0c, 1'b0);
      mgt_req = 1'b1;
      sys_req = 1'b1;
      settle;
      repeat (4) begin
         @(negedge i_clk);
         check("irq_pins", {6'h00, irq_pins}, 8'h03);
      end
      mgt_req = 1'b0;
      sys_req = 1'b0;
      repeat (8) @(negedge i_clk);
      check("irq_pins", {6'h00, irq_pins}, 8'h00);
      // pulse train on management line, then on status line, the other line stays level
      ext_mode = 1'b1;
      pat = 5'b10011;
      reg_write(12'h016, 8'h04, 1'b0);
      mgt_req = 1'b1;
      sys_req = 1'b1;
      for (int k = 0; k < 5; k++) begin
         @(negedge i_clk);
         check("mgt_irq", {7'h00, irq_pins[0]}, {7'h00, pat[k]});
         check("sys_irq", {7'h00, irq_pins[1]}, 8'h01);
      end
      mgt_req = 1'b0;
      sys_req = 1'b0;
      repeat (8) @(negedge i_clk);
      reg_write(12'h016, 8'h08, 1'b0);
      mgt_req = 1'b1;
      sys_req = 1'b1;
      for (int k = 0; k < 5; k++) begin
         @(negedge i_clk);
         check("sys_irq", {7'h00, irq_pins[1]}, {7'h00, pat[k]});
         check("mgt_irq", {7'h00, irq_pins[0]}, 8'h01);
      end
      mgt_req = 1'b0;
      sys_req = 1'b0;
      // speaker floats while off, then mixes enabled sockets
      present = 2'b11;
      sock_en = 2'b11;
      reg_write(12'h016, 8'h00, 1'b0);
      settle;
      check("aud_oe_n", {7'h00, aud_oe_n}, 8'h01);
      reg_write(12'h016, 8'h10, 1'b0);
      for (int k = 0; k < 6; k++) begin
         card_spkr = 2'($random(seed));
         sock_en = (k > 3) ? 2'b01 : 2'b11;
         exp_b = (k > 3) ? card_spkr[0] : ~(card_spkr[0] ^ card_spkr[1]);
         repeat (5) @(negedge i_clk);
         check("aud_oe_n", {7'h00, aud_oe_n}, 8'h00);
         check("audio_out", {7'h00, aud}, {7'h00, exp_b});
      end
      // empty sockets leave both pins on their pull-ups
      present = 2'b00;
      sock_en = 2'b11;
      repeat (5) @(negedge i_clk);
      check("audio_out", {7'h00, aud}, 8'h01);
      settle;
      test_done;
   end

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      bad_count++;
      test_done;
   end
endmodule
